// ---- logic/csssu_pkg.sv ----
// Shared constants and types for the compare, shift, subtract and store unit.
package csssu_pkg;

  // ==========================================================================
  // Widths.
  localparam int unsigned GPR_W = 64;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned REG_IDX_W = 5;
  localparam int unsigned SHAMT_W = 5;
  localparam int unsigned OPC_W = 6;
  localparam int unsigned PADDR_W = 36;
  localparam int unsigned LANE_W = 3;
  localparam int unsigned BE_W = 8;
  localparam int unsigned WORD_SIGN_BIT = 31;
  localparam int unsigned PADDR_LANE_BIT = 2;

  // ==========================================================================
  // Primary opcodes and function codes.
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_LT_IMM_U = 6'h0B;
  localparam logic [5:0] OP_WORD_STORE = 6'h2B;
  localparam logic [5:0] FN_LSR_FIXED = 6'h02;
  localparam logic [5:0] FN_ASR_FIXED = 6'h03;
  localparam logic [5:0] FN_LSR_VAR = 6'h06;
  localparam logic [5:0] FN_ASR_VAR = 6'h07;
  localparam logic [5:0] FN_SUB_TRAP = 6'h22;
  localparam logic [5:0] FN_SUB_WRAP = 6'h23;
  localparam logic [5:0] FN_LT_REG_U = 6'h2B;

  // ==========================================================================
  // Field values.
  localparam logic [4:0] SHAMT_ZERO = 5'h00;
  localparam logic [1:0] ALIGN_ZERO = 2'h0;
  localparam logic [7:0] WORD_BE = 8'h0F;
  localparam logic [63:0] GPR_ZERO = 64'h0;
  localparam logic [63:0] GPR_ONE = 64'h1;
  localparam logic [63:0] LOW_WORD_MASK = 64'h0000_0000_FFFF_FFFF;

  // ==========================================================================
  // Exception causes reported with a finished instruction.
  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_INT_OVERFLOW = 3'b001,
    EXC_ADDR_ERROR = 3'b010,
    EXC_TLB_REFILL = 3'b011,
    EXC_TLB_INVALID = 3'b100,
    EXC_TLB_MODIFIED = 3'b101
  } csssu_exc_t;

  // ==========================================================================
  // Registered state of the unit, all but the effective address held in eff_vaddr_r.
  typedef struct packed {
    logic done;
    logic wb_en;
    logic [4:0] wb_idx;
    logic [63:0] wb_data;
    logic exc_valid;
    csssu_exc_t exc_code;
    logic [63:0] exc_vaddr;
    logic st_valid;
    logic [35:0] st_paddr;
    logic [63:0] st_data;
    logic [7:0] st_be;
  } csssu_state_t;

  localparam csssu_state_t STATE_RESET = '{
    done: 1'b0,
    wb_en: 1'b0,
    wb_idx: 5'h00,
    wb_data: 64'h0,
    exc_valid: 1'b0,
    exc_code: EXC_NONE,
    exc_vaddr: 64'h0,
    st_valid: 1'b0,
    st_paddr: 36'h0,
    st_data: 64'h0,
    st_be: 8'h00
  };

endpackage

// ---- logic/csssu_top.sv ----
// Compare, shift, subtract and word store execution datapath.
// Contract
// - Immediate unsigned less-than: sign-extend imm16, compare unsigned, write 1 or 0.
// - Register unsigned less-than (function 101011, shift field zero) writes 1 or 0.
// - Neither unsigned comparison ever raises integer overflow.
// - Fixed arithmetic right shift of low word, filling with bit 31.
// - Variable shifts take count from source A bits 4..0.
// - Logical right shifts fill vacated upper bits with zeros.
// - On 64-bit cores shift results are sign-extended from bit 31.
// - Trapping subtract: on signed overflow no write, overflow exception raised.
// - Wrapping subtract writes modulo difference, never signals overflow.
// - Word store address is base plus sign-extended offset; stores low word.
// - Misaligned word store raises address error and writes no memory.
// - 64-bit lane from address xor big-endian; address bit 2 xor swap flag.
// - Word store reports translation refill, invalid and modified faults.
`timescale 1ns/1ps

module csssu_top #(
  parameter bit CORE_IS_64 = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic issue_valid,
  input wire logic [5:0] opcode,
  input wire logic [5:0] funct,
  input wire logic [4:0] shift_amount_field,
  input wire logic [4:0] dest_idx,
  input wire logic [4:0] source_b_idx,
  input wire logic [15:0] imm,
  input wire logic [63:0] source_a_reg,
  input wire logic [63:0] source_b_reg,
  input wire logic [35:0] xlat_paddr,
  input wire logic xlat_tlb_refill,
  input wire logic xlat_tlb_invalid,
  input wire logic xlat_tlb_modified,
  input wire logic big_endian_core_flag,
  input wire logic swap_byte_order_flag,
  output logic done,
  output logic wb_en,
  output logic [4:0] wb_idx,
  output logic [63:0] wb_data,
  output logic exc_valid,
  output csssu_pkg::csssu_exc_t exc_code,
  output logic [63:0] exc_vaddr,
  output logic st_valid,
  output logic [35:0] st_paddr,
  output logic [63:0] st_data,
  output logic [7:0] st_be,
  output logic [63:0] eff_vaddr
);
  import csssu_pkg::*;

  csssu_state_t state_r;
  csssu_state_t state_nxt;
  logic [63:0] eff_vaddr_r;
  logic [63:0] eff_vaddr_nxt;

  logic [63:0] width_mask;
  logic [63:0] imm_sext;
  logic [63:0] cmp_a;
  logic [63:0] cmp_b_reg;
  logic [63:0] cmp_b_imm;
  logic lt_reg;
  logic lt_imm;
  logic [31:0] diff_word;
  logic sub_overflow;
  logic [63:0] diff_wide;
  logic shift_arith;
  logic [4:0] shift_count;
  logic [63:0] shift_result;
  logic [63:0] vaddr;
  logic misaligned;
  logic [2:0] lane;
  logic [5:0] lane_bits;
  logic [63:0] store_word;
  logic is_shift;
  logic is_special;
  logic store_fault;
  csssu_exc_t store_exc;
  logic [35:0] store_paddr;
  logic [63:0] store_data;
  logic [7:0] store_be;

  // ==========================================================================
  // Operand width masking.
  always_comb begin
    width_mask = CORE_IS_64 ? ~GPR_ZERO : LOW_WORD_MASK;
    cmp_a = source_a_reg & width_mask;
    cmp_b_reg = source_b_reg & width_mask;
  end

  // ==========================================================================
  // Immediate sign extension.
  always_comb begin
    imm_sext = {{48{imm[15]}}, imm} & width_mask;
    cmp_b_imm = imm_sext;
  end

  // ==========================================================================
  // Unsigned comparisons, which never trap.
  always_comb begin
    lt_reg = cmp_a < cmp_b_reg;
    lt_imm = cmp_a < cmp_b_imm;
  end

  // ==========================================================================
  // Word subtraction and signed overflow detection.
  always_comb begin
    diff_word = source_a_reg[31:0] - source_b_reg[31:0];
    sub_overflow = (source_a_reg[WORD_SIGN_BIT] != source_b_reg[WORD_SIGN_BIT])
      && (diff_word[WORD_SIGN_BIT] != source_a_reg[WORD_SIGN_BIT]);
  end

  // ==========================================================================
  // Widening of the subtraction result.
  always_comb begin
    if (CORE_IS_64) begin
      diff_wide = {{32{diff_word[WORD_SIGN_BIT]}}, diff_word};
    end else begin
      diff_wide = {32'h0, diff_word};
    end
  end

  // ==========================================================================
  // Instruction class decode.
  always_comb begin
    is_special = opcode == OP_SPECIAL;
    is_shift = is_special && (funct == FN_LSR_FIXED
      || funct == FN_ASR_FIXED || funct == FN_LSR_VAR
      || funct == FN_ASR_VAR);
  end

  // ==========================================================================
  // Shift control.
  always_comb begin
    shift_arith = funct == FN_ASR_FIXED || funct == FN_ASR_VAR;
    if (funct == FN_LSR_VAR || funct == FN_ASR_VAR) begin
      shift_count = source_a_reg[4:0];
    end else begin
      shift_count = shift_amount_field;
    end
  end

  csssu_word_shift u_shift (
    .word_in(source_b_reg[31:0]),
    .amount(shift_count),
    .arith(shift_arith),
    .core_is_64(CORE_IS_64),
    .result(shift_result)
  );

  // ==========================================================================
  // Word store address and alignment.
  always_comb begin
    vaddr = (source_a_reg + imm_sext) & width_mask;
    misaligned = vaddr[1:0] != ALIGN_ZERO;
  end

  // ==========================================================================
  // Byte lane placement and physical address.
  always_comb begin
    if (CORE_IS_64) begin
      lane = vaddr[2:0] ^ {big_endian_core_flag, 2'b00};
    end else begin
      lane = 3'h0;
    end
    lane_bits = {lane, 3'b000};
    store_word = {32'h0, source_b_reg[31:0]};
    store_paddr = xlat_paddr;
    if (CORE_IS_64) begin
      store_paddr[PADDR_LANE_BIT] =
        xlat_paddr[PADDR_LANE_BIT] ^ swap_byte_order_flag;
    end
    store_data = store_word << lane_bits;
    store_be = WORD_BE << lane;
  end

  // ==========================================================================
  // Word store fault priority.
  always_comb begin
    store_fault = 1'b1;
    store_exc = EXC_NONE;
    if (misaligned) begin
      store_exc = EXC_ADDR_ERROR;
    end else if (xlat_tlb_refill) begin
      store_exc = EXC_TLB_REFILL;
    end else if (xlat_tlb_invalid) begin
      store_exc = EXC_TLB_INVALID;
    end else if (xlat_tlb_modified) begin
      store_exc = EXC_TLB_MODIFIED;
    end else begin
      store_fault = 1'b0;
    end
  end

  // ==========================================================================
  // Next state.
  always_comb begin
    state_nxt = STATE_RESET;
    eff_vaddr_nxt = eff_vaddr_r;
    if (issue_valid) begin
      case (opcode)
        OP_LT_IMM_U: begin
          state_nxt.done = 1'b1;
          state_nxt.wb_en = 1'b1;
          state_nxt.wb_idx = source_b_idx;
          state_nxt.wb_data = lt_imm ? GPR_ONE : GPR_ZERO;
        end
        OP_WORD_STORE: begin
          state_nxt.done = 1'b1;
          eff_vaddr_nxt = vaddr;
          if (store_fault) begin
            state_nxt.exc_valid = 1'b1;
            state_nxt.exc_code = store_exc;
            state_nxt.exc_vaddr = vaddr;
          end else begin
            state_nxt.st_valid = 1'b1;
            state_nxt.st_paddr = store_paddr;
            state_nxt.st_data = store_data;
            state_nxt.st_be = store_be;
          end
        end
        OP_SPECIAL: begin
          case (funct)
            FN_LT_REG_U: begin
              if (shift_amount_field == SHAMT_ZERO) begin
                state_nxt.done = 1'b1;
                state_nxt.wb_en = 1'b1;
                state_nxt.wb_idx = dest_idx;
                state_nxt.wb_data = lt_reg ? GPR_ONE : GPR_ZERO;
              end
            end
            FN_SUB_TRAP: begin
              state_nxt.done = 1'b1;
              if (sub_overflow) begin
                state_nxt.exc_valid = 1'b1;
                state_nxt.exc_code = EXC_INT_OVERFLOW;
              end else begin
                state_nxt.wb_en = 1'b1;
                state_nxt.wb_idx = dest_idx;
                state_nxt.wb_data = diff_wide;
              end
            end
            FN_SUB_WRAP: begin
              state_nxt.done = 1'b1;
              state_nxt.wb_en = 1'b1;
              state_nxt.wb_idx = dest_idx;
              state_nxt.wb_data = diff_wide;
            end
            default: begin
              if (is_shift) begin
                state_nxt.done = 1'b1;
                state_nxt.wb_en = 1'b1;
                state_nxt.wb_idx = dest_idx;
                state_nxt.wb_data = shift_result;
              end
            end
          endcase
        end
        default: begin
          state_nxt = STATE_RESET;
        end
      endcase
      if (state_nxt.exc_valid) begin
        state_nxt.wb_en = 1'b0;
        state_nxt.wb_data = GPR_ZERO;
      end
    end
  end

  // ==========================================================================
  // State registers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= STATE_RESET;
      eff_vaddr_r <= GPR_ZERO;
    end else begin
      state_r <= state_nxt;
      eff_vaddr_r <= eff_vaddr_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  always_comb begin
    done = state_r.done;
    wb_en = state_r.wb_en;
    wb_idx = state_r.wb_idx;
    wb_data = state_r.wb_data;
    exc_valid = state_r.exc_valid;
    exc_code = state_r.exc_code;
    exc_vaddr = state_r.exc_vaddr;
    st_valid = state_r.st_valid;
    st_paddr = state_r.st_paddr;
    st_data = state_r.st_data;
    st_be = state_r.st_be;
    eff_vaddr = eff_vaddr_r;
  end

endmodule

// ---- logic/csssu_word_shift.sv ----
// Right shifter for the low word of a register with word sign extension.
`timescale 1ns/1ps

module csssu_word_shift (
  input wire logic [31:0] word_in,
  input wire logic [4:0] amount,
  input wire logic arith,
  input wire logic core_is_64,
  output logic [63:0] result
);
  import csssu_pkg::*;

  logic fill;
  logic [63:0] wide;
  logic [31:0] shifted;

  // ==========================================================================
  // Shift with zero or sign fill, then widen from bit 31.
  always_comb begin
    fill = arith & word_in[WORD_SIGN_BIT];
    wide = {{32{fill}}, word_in} >> amount;
    shifted = wide[31:0];
    if (core_is_64) begin
      result = {{32{shifted[WORD_SIGN_BIT]}}, shifted};
    end else begin
      result = {32'h0, shifted};
    end
  end

endmodule

// ---- tb/csssu_props.sv ----
// Assertion checker for the compare, shift, subtract and store unit.
`timescale 1ns/1ps

module csssu_props #(
  parameter bit CORE_IS_64 = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic issue_valid,
  input wire logic [5:0] opcode,
  input wire logic [5:0] funct,
  input wire logic [4:0] shift_amount_field,
  input wire logic [15:0] imm,
  input wire logic [63:0] source_a_reg,
  input wire logic [63:0] source_b_reg,
  input wire logic big_endian_core_flag,
  input wire logic done,
  input wire logic wb_en,
  input wire logic [63:0] wb_data,
  input wire logic exc_valid,
  input wire csssu_pkg::csssu_exc_t exc_code,
  input wire logic st_valid,
  input wire logic [7:0] st_be,
  input wire logic [63:0] eff_vaddr
);
  import csssu_pkg::*;
  logic [63:0] sx;
  logic [63:0] ea;
  logic [31:0] dif;
  logic [31:0] asr;
  logic [63:0] asr64;
  logic lti;
  logic ovf;
  logic spec;
  logic st;
  assign sx = {{48{imm[15]}}, imm};
  assign ea = source_a_reg + sx;
  assign dif = source_a_reg[31:0] - source_b_reg[31:0];
  assign asr = $signed(source_b_reg[31:0]) >>> shift_amount_field;
  assign asr64 = {{32{asr[31]}}, asr};
  assign lti = source_a_reg < sx;
  assign ovf = (source_a_reg[31] != source_b_reg[31]) &&
    (dif[31] != source_a_reg[31]);
  assign spec = issue_valid && opcode == OP_SPECIAL;
  assign st = issue_valid && opcode == OP_WORD_STORE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_lt_imm;
    issue_valid && opcode == OP_LT_IMM_U |=>
      done && wb_en && !exc_valid && wb_data == {63'h0, $past(lti)};
  endproperty
  a_lt_imm: assert property (p_lt_imm)
    else $error("immediate compare result wrong");
  property p_lt_reg;
    spec && funct == FN_LT_REG_U |=>
      !exc_valid && done == ($past(shift_amount_field) == 5'h00);
  endproperty
  a_lt_reg: assert property (p_lt_reg)
    else $error("register compare done wrong");
  property p_wrap;
    spec && funct == FN_SUB_WRAP |=> done && wb_en && !exc_valid;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrapping subtract wrong");
  property p_trap;
    spec && funct == FN_SUB_TRAP && ovf |=>
      exc_valid && exc_code == EXC_INT_OVERFLOW && !wb_en;
  endproperty
  a_trap: assert property (p_trap)
    else $error("overflow not trapped");
  property p_no_wb;
    exc_valid |-> done && !wb_en;
  endproperty
  a_no_wb: assert property (p_no_wb)
    else $error("write-back with exception");
  property p_align;
    st && ea[1:0] != ALIGN_ZERO |=> exc_code == EXC_ADDR_ERROR && !st_valid;
  endproperty
  a_align: assert property (p_align)
    else $error("misaligned store not refused");
  property p_eff;
    st && ea[1:0] == ALIGN_ZERO |=> eff_vaddr == $past(ea);
  endproperty
  a_eff: assert property (p_eff)
    else $error("store address wrong");
  property p_asr;
    spec && funct == FN_ASR_FIXED && CORE_IS_64 |=>
      wb_en && wb_data == $past(asr64);
  endproperty
  a_asr: assert property (p_asr)
    else $error("arithmetic shift wrong");
  property p_lane;
    st_valid && CORE_IS_64 |-> st_be ==
      ((eff_vaddr[2] ^ $past(big_endian_core_flag)) ? 8'hF0 : 8'h0F);
  endproperty
  a_lane: assert property (p_lane)
    else $error("store lane wrong");
endmodule

bind csssu_top csssu_props #(.CORE_IS_64(CORE_IS_64)) u_props (
  .clk(clk),
  .reset(reset),
  .issue_valid(issue_valid),
  .opcode(opcode),
  .funct(funct),
  .shift_amount_field(shift_amount_field),
  .imm(imm),
  .source_a_reg(source_a_reg),
  .source_b_reg(source_b_reg),
  .big_endian_core_flag(big_endian_core_flag),
  .done(done),
  .wb_en(wb_en),
  .wb_data(wb_data),
  .exc_valid(exc_valid),
  .exc_code(exc_code),
  .st_valid(st_valid),
  .st_be(st_be),
  .eff_vaddr(eff_vaddr)
);

// ---- tb/csssu_xlat_model.sv ----
// Address translation stand-in for the far side of the store path.
`timescale 1ns/1ps

module csssu_xlat_model (
  input wire logic [63:0] vaddr,
  input wire logic [1:0] fault_sel,
  output logic [35:0] paddr,
  output logic refill,
  output logic invalid,
  output logic modified
);
  assign paddr = {4'h5, vaddr[31:0]};
  assign refill = fault_sel == 2'h1;
  assign invalid = fault_sel == 2'h2;
  assign modified = fault_sel == 2'h3;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench for the compare, shift, subtract and store unit.
`timescale 1ns/1ps

module tb_top;
  import csssu_pkg::*;
  logic clk, reset, iv, be, sw, done, wb_en, exc_valid, st_valid, rf, ri, rm;
  logic [5:0] op, fn;
  logic [4:0] sa, di, bi, wb_idx;
  logic [15:0] im;
  logic [63:0] a, b, wb_data, exc_vaddr, st_data, eff_vaddr, va;
  logic [35:0] pa, st_paddr;
  logic [7:0] st_be;
  logic [1:0] flt;
  logic [11:0] enc [10];
  csssu_exc_t exc_code;
  int miscompares = 0;
  int n_compared = 0;
  assign va = a + {{48{im[15]}}, im};
  csssu_xlat_model xm (.vaddr(va), .fault_sel(flt), .paddr(pa),
    .refill(rf), .invalid(ri), .modified(rm));
  csssu_top uut (.clk(clk), .reset(reset), .issue_valid(iv), .opcode(op),
    .funct(fn), .shift_amount_field(sa), .dest_idx(di), .source_b_idx(bi),
    .imm(im), .source_a_reg(a), .source_b_reg(b), .xlat_paddr(pa),
    .xlat_tlb_refill(rf), .xlat_tlb_invalid(ri), .xlat_tlb_modified(rm),
    .big_endian_core_flag(be), .swap_byte_order_flag(sw), .done(done),
    .wb_en(wb_en), .wb_idx(wb_idx), .wb_data(wb_data),
    .exc_valid(exc_valid), .exc_code(exc_code), .exc_vaddr(exc_vaddr),
    .st_valid(st_valid), .st_paddr(st_paddr), .st_data(st_data),
    .st_be(st_be), .eff_vaddr(eff_vaddr));

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [63:0] g,
    input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic cmp_wb(input logic [63:0] g, input logic [63:0] e);
    cmp("write-back", g, e);
  endtask

  task automatic cmp_exc(input logic [63:0] g, input logic [63:0] e);
    cmp("exception", g, e);
  endtask

  task automatic cmp_st(input logic [63:0] g, input logic [63:0] e);
    cmp("store", g, e);
  endtask

  function automatic logic [63:0] rv();
    logic [31:0] w;
    case ($urandom % 5)
      0: w = 32'h7FFF_FFFF;
      1: w = 32'h8000_0000;
      default: w = $urandom;
    endcase
    return {{32{w[31]}}, w};
  endfunction

  task automatic step();
    logic [63:0] ewd, ev, esd;
    logic [31:0] d;
    logic [4:0] s, ei;
    logic [2:0] ln;
    logic [35:0] epa;
    logic [7:0] ebe;
    logic ed, ew, ex, es, ovf;
    csssu_exc_t ec;
    {ed, ew, ex, es, ovf} = 5'h00;
    {ewd, ev, esd, epa, ebe, ei, d} = '0;
    ec = EXC_NONE;
    if (iv && op == OP_LT_IMM_U) begin
      {ed, ew, ei} = {2'b11, bi};
      ewd = {63'h0, a < {{48{im[15]}}, im}};
    end
    if (iv && op == OP_WORD_STORE) begin
      ed = 1'b1;
      ln = va[2:0] ^ {be, 2'b00};
      if (va[1:0] != 2'h0 || flt != 2'h0) begin
        ex = 1'b1;
        ev = va;
        ec = va[1:0] != 2'h0 ? EXC_ADDR_ERROR : csssu_exc_t'(flt + 3'h2);
      end else begin
        es = 1'b1;
        epa = pa ^ {33'h0, sw, 2'b00};
        esd = {32'h0, b[31:0]} << (8 * ln);
        ebe = 8'h0F << ln;
      end
    end
    if (iv && op == OP_SPECIAL) begin
      s = fn[2] ? a[4:0] : sa;
      ed = 1'b1;
      case (fn)
        FN_LSR_FIXED, FN_LSR_VAR: d = b[31:0] >> s;
        FN_ASR_FIXED, FN_ASR_VAR: d = $signed(b[31:0]) >>> s;
        FN_SUB_TRAP, FN_SUB_WRAP: d = a[31:0] - b[31:0];
        FN_LT_REG_U: begin
          d = {31'h0, a < b};
          ed = sa == 5'h00;
        end
        default: ed = 1'b0;
      endcase
      ovf = fn == FN_SUB_TRAP && a[31] != b[31] && d[31] != a[31];
      ex = ed && ovf;
      ew = ed && !ovf;
      if (ex) ec = EXC_INT_OVERFLOW;
      if (ew) ewd = {{32{d[31]}}, d};
      if (ew) ei = di;
    end
    cmp_wb(64'(done), 64'(ed));
    cmp_wb(64'(wb_en), 64'(ew));
    cmp_wb(64'(wb_idx), 64'(ei));
    cmp_wb(wb_data, ewd);
    cmp_exc(64'(exc_valid), 64'(ex));
    cmp_exc(64'(exc_code), 64'(ec));
    cmp_exc(exc_vaddr, ev);
    cmp_st(64'(st_valid), 64'(es));
    cmp_st(64'(st_paddr), 64'(epa));
    cmp_st(st_data, esd);
    cmp_st(64'(st_be), 64'(ebe));
    if (es) cmp_st(eff_vaddr, va);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    miscompares++;
    test_done();
  end

  initial begin
    int k;
    enc = '{{OP_LT_IMM_U, 6'h00}, {OP_WORD_STORE, 6'h00},
      {OP_SPECIAL, FN_LT_REG_U}, {OP_SPECIAL, FN_LSR_FIXED},
      {OP_SPECIAL, FN_ASR_FIXED}, {OP_SPECIAL, FN_LSR_VAR},
      {OP_SPECIAL, FN_ASR_VAR}, {OP_SPECIAL, FN_SUB_TRAP},
      {OP_SPECIAL, FN_SUB_WRAP}, {OP_SPECIAL, 6'h3F}};
    {reset, iv, be, sw, op, fn, sa, di, bi, im, flt} = '0;
    reset = 1'b1;
    {a, b} = '0;
    void'($urandom(32'h44C8));
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      step();
      k = $urandom % 10;
      {op, fn} = enc[k];
      iv = $urandom % 8 != 0;
      a = rv();
      b = rv();
      {im, sa, di, bi, be, sw} = 33'({$urandom, $urandom});
      flt = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
      if (op == OP_WORD_STORE) begin
        im[1:0] = 2'h0;
        if ($urandom % 3 != 0) a[1:0] = 2'h0;
      end
      if (k == 2 && $urandom % 4 != 0) sa = 5'h00;
    end
    @(posedge clk);
    #1;
    step();
    test_done();
  end
endmodule
